//--- rtl/qrbsp_port.sv
// Purpose: separate-port burst-of-four sram: selects, bursts, lanes, forwarding
// Assumes: each cycle carries the positive and negative beat of the input pair
// Notes: select, pll-off and strap pins pass two flip-flops, address, data and lane pins one; outputs come from flip-flops
`default_nettype none
module qrbsp_port
    import qrbsp_pkg::*;
#(
    parameter int unsigned LOCK_CYCLES = QRB_LOCK_CYCLES
) (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic CE,
    input wire logic READ_PORT_SELECT_N,
    input wire logic WRITE_PORT_SELECT_N,
    input wire logic [QRB_ADDR_W-1:0] ADDR,
    input wire logic [QRB_WORD_W-1:0] DATA_IN_POS,
    input wire logic [QRB_WORD_W-1:0] DATA_IN_NEG,
    input wire logic [QRB_LANES-1:0] BYTE_LANE_WRITE_N_POS,
    input wire logic [QRB_LANES-1:0] BYTE_LANE_WRITE_N_NEG,
    input wire logic PLL_OFF_N,
    input wire logic OUT_CLK_STRAP,
    output logic [QRB_WORD_W-1:0] DATA_OUT,
    output logic DATA_OUT_OE,
    output logic ECHO_CLOCK,
    output logic ECHO_CLOCK_N,
    output logic SINGLE_CLOCK,
    output logic PLL_LOCKED,
    output logic IMPEDANCE_CAL
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [1:0] rps_s, wps_s, pll_off_n_s, strap_s;
        qrbsp_addr_t addr_s;
        qrbsp_word_t dp_s, dn_s;
        logic [QRB_LANES-1:0] bp_s, bn_s;
        logic [1:0] strap_cnt;
        logic single;
        qrbsp_last_e last;
        logic [2:0] wr_pipe;
        qrbsp_addr_t wa0, wa1, wa2, wc_addr;
        logic [QRB_BURST*QRB_WORD_W-1:0] wbuf;
        logic [QRB_BURST*QRB_LANES-1:0] wlan;
        logic wr_commit;
        logic [3:0] rd_ph;
        qrbsp_addr_t rd_addr;
        logic [1:0] rd_idx;
        logic rd_pend;
        qrbsp_word_t q;
        logic oe;
        logic echo;
        logic echo_n;
    } qrbsp_port_s;
    qrbsp_port_s r, next_r;

    qrbsp_wr_if wr_c ();
    qrbsp_word_t arr_q;
    qrbsp_addr_t arr_raddr;
    logic cal, locked;

    qrbsp_array u_array (
        .clk(CLK),
        .ce(CE),
        .wr(wr_c),
        .rd_addr(arr_raddr),
        .rd_data(arr_q)
    );
    qrbsp_zq #(.LOCK_CYCLES(LOCK_CYCLES)) u_zq (
        .clk(CLK),
        .reset_n(RESET_N),
        .ce(CE),
        .pll_on(r.pll_off_n_s[1]),
        .cal_pulse(cal),
        .locked(locked)
    );

    logic rd_req, wr_req, rd_go, wr_go, rd_busy, wr_busy;
    logic [1:0] rd_slot;
    logic fwd_hit;
    qrbsp_word_t rd_word;

    // ----------------------------------------
    // start decisions
    // ----------------------------------------
    always_comb begin
        // a port busy with its first cycle refuses a new start
        rd_busy = (r.last == QRB_LAST_READ);
        wr_busy = (r.last == QRB_LAST_WRITE);
        rd_req = !r.rps_s[1] && !rd_busy;
        wr_req = !r.wps_s[1] && !wr_busy;
        // both selected: after idle read wins, else the other port wins
        rd_go = rd_req;
        wr_go = wr_req && !rd_req;
        rd_slot = r.rd_idx;
        arr_raddr = r.rd_addr + QRB_ADDR_W'(rd_slot);
    end

    // ----------------------------------------
    // write commit: whole burst in one cycle
    // ----------------------------------------
    always_comb begin
        wr_c.we = r.wr_commit;
        wr_c.addr = r.wc_addr;
        wr_c.data = r.wbuf;
        wr_c.lane_en = r.wlan;
    end

    // the array only sees the commit at the edge, so a read in that cycle takes the new bytes
    always_comb begin
        rd_word = arr_q;
        fwd_hit = 1'b0;
        for (int k = 0; k < QRB_BURST; k++) begin
            if (wr_c.we && (wr_c.addr + QRB_ADDR_W'(k)) == arr_raddr) begin
                fwd_hit = 1'b1;
                for (int l = 0; l < QRB_LANES; l++) begin
                    if (wr_c.lane_en[k*QRB_LANES+l]) begin
                        rd_word[l*QRB_LANE_W +: QRB_LANE_W] =
                            wr_c.data[(k*QRB_LANES+l)*QRB_LANE_W +: QRB_LANE_W];
                    end
                end
            end
        end
    end

    // ----------------------------------------
    // main sequencing
    // ----------------------------------------
    always_comb begin
        next_r = r;
        next_r.rps_s = {r.rps_s[0], READ_PORT_SELECT_N};
        next_r.wps_s = {r.wps_s[0], WRITE_PORT_SELECT_N};
        next_r.pll_off_n_s = {r.pll_off_n_s[0], PLL_OFF_N};
        next_r.strap_s = {r.strap_s[0], OUT_CLK_STRAP};
        next_r.addr_s = ADDR;
        next_r.dp_s = DATA_IN_POS;
        next_r.dn_s = DATA_IN_NEG;
        next_r.bp_s = BYTE_LANE_WRITE_N_POS;
        next_r.bn_s = BYTE_LANE_WRITE_N_NEG;
        // strap taken once the pin has crossed both sync flops
        if (r.strap_cnt != 2'h3) begin
            next_r.strap_cnt = r.strap_cnt + 2'h1;
        end
        if (r.strap_cnt == 2'h2) begin
            next_r.single = r.strap_s[1];
        end
        next_r.echo = ~r.echo;
        next_r.echo_n = r.echo;
        next_r.last = rd_go ? QRB_LAST_READ : (wr_go ? QRB_LAST_WRITE : QRB_LAST_IDLE);
        // write: a pipe, so a start two cycles later overlaps without clobbering
        next_r.wr_pipe = {r.wr_pipe[1:0], wr_go};
        next_r.wa0 = r.addr_s;
        next_r.wa1 = r.wa0;
        next_r.wa2 = r.wa1;
        next_r.wr_commit = 1'b0;
        if (r.wr_pipe[1]) begin
            next_r.wbuf[0 +: 2*QRB_WORD_W] = {r.dn_s, r.dp_s};
            next_r.wlan[0 +: 2*QRB_LANES] = ~{r.bn_s, r.bp_s};
        end
        if (r.wr_pipe[2]) begin
            next_r.wbuf[2*QRB_WORD_W +: 2*QRB_WORD_W] = {r.dn_s, r.dp_s};
            next_r.wlan[2*QRB_LANES +: 2*QRB_LANES] = ~{r.bn_s, r.bp_s};
            next_r.wr_commit = 1'b1;
            next_r.wc_addr = r.wa2;
        end
        // read: one word each cycle, lowest first
        next_r.oe = 1'b0;
        if (r.rd_pend) begin
            next_r.q = rd_word;
            next_r.oe = 1'b1;
            next_r.rd_idx = r.rd_idx + 2'h1;
            if (r.rd_idx == 2'h3) begin
                next_r.rd_pend = 1'b0;
            end
        end
        if (rd_go) begin
            next_r.rd_addr = r.addr_s;
            next_r.rd_idx = 2'h0;
            next_r.rd_pend = 1'b1;
            next_r.rd_ph = r.pll_off_n_s[1] ? 4'h1 : 4'h0;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            r <= '{rps_s: 2'h3, wps_s: 2'h3, pll_off_n_s: 2'h3, last: QRB_LAST_IDLE,
                   default: '0};
        end else if (CE) begin
            r <= next_r;
        end
    end

    assign DATA_OUT = r.q;
    assign DATA_OUT_OE = r.oe;
    assign ECHO_CLOCK = r.echo;
    assign ECHO_CLOCK_N = r.echo_n;
    assign SINGLE_CLOCK = r.single;
    assign PLL_LOCKED = locked;
    assign IMPEDANCE_CAL = cal;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    no_double_read_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        CE && rd_go |=> !CE || !rd_go)
        else $error("read started on consecutive rises");
    no_double_write_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        CE && wr_go |=> !CE || !wr_go)
        else $error("write started on consecutive rises");
    one_start_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        !(rd_go && wr_go))
        else $error("two starts in one cycle");
    read_wins_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        CE && rd_req && !r.wps_s[1] && r.last == QRB_LAST_IDLE |-> rd_go && !wr_go)
        else $error("read lost arbitration after idle");
    burst_len_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        CE && rd_go ##1 CE ##1 CE[*4] |-> $past(DATA_OUT_OE, 3) && DATA_OUT_OE)
        else $error("burst length");
    out_after_read_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        CE && rd_go ##1 CE ##1 CE |-> DATA_OUT_OE)
        else $error("read data not driven");
    idle_tristate_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        CE && !r.rd_pend |=> !CE || !DATA_OUT_OE)
        else $error("outputs driven with no burst");
    write_commit_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        CE && wr_go ##1 CE ##1 CE ##1 CE ##1 CE |-> wr_c.we)
        else $error("write not committed");
    strap_hold_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        r.strap_cnt == 2'h3 |=> $stable(r.single))
        else $error("strap changed");
    echo_run_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        CE |=> ECHO_CLOCK != $past(ECHO_CLOCK))
        else $error("echo clock stopped");
    read_c: cover property (@(posedge CLK) rd_go ##2 DATA_OUT_OE);
    write_c: cover property (@(posedge CLK) wr_go ##4 wr_c.we);
    forward_c: cover property (@(posedge CLK) fwd_hit && r.rd_pend);
    alt_c: cover property (@(posedge CLK) rd_go ##1 wr_go ##1 rd_go);
endmodule
`default_nettype wire

//--- common/qrbsp_pkg.sv
// Purpose: constants and types shared by the burst-of-four SRAM port logic
// Assumes: one 100 MHz clock; the input clock pair is modelled as two beats per cycle
// Notes: depth of the modelled array is kept small for simulation
//
// Summary of operation
// - read starts on active read select
// - four 18-bit words per access, written in two cycles, read out in four
// - latency 2 cycles from the read start, the same with pll off
// - lowest-order read word first, then successive
// - second back-to-back read is ignored
// - alternate-cycle reads restart the burst, cutting the earlier one to two words
// - finish read burst, then tristate outputs
// - write starts on active write select
// - capture four words, commit 72 bits
// - second back-to-back write is ignored
// - deselected write port ignores inputs
// - byte lanes sampled with every word
// - single clock strap caught at power on
// - read started three or more cycles after a write start returns newest data
// - both selected: arbitrate on previous start
// - selects sampled on rise; ports independent
// - impedance recalibrated every 1024 cycles
// - two free-running echo clocks
// - pll lock after 20 microseconds
// - pll off holds pll lock low; read timing unchanged
// - powers up deselected, outputs tristated
// - write data on two following cycles
// - byte-lane write selects are active low
`default_nettype none
package qrbsp_pkg;
    localparam int unsigned QRB_WORD_W = 18;
    localparam int unsigned QRB_LANES = 2;
    localparam int unsigned QRB_LANE_W = 9;
    localparam int unsigned QRB_ADDR_W = 8;
    localparam int unsigned QRB_BURST = 4;
    localparam int unsigned QRB_CLK_MHZ = 100;
    localparam int unsigned QRB_ZQ_CYCLES = 1024;
    localparam int unsigned QRB_LOCK_US = 20;
    localparam int unsigned QRB_LOCK_CYCLES = QRB_LOCK_US * QRB_CLK_MHZ;
    localparam int unsigned QRB_RESET_NS = 30;
    localparam int unsigned QRB_RESET_CYCLES = (QRB_RESET_NS * QRB_CLK_MHZ + 999) / 1000;
    typedef logic [QRB_ADDR_W-1:0] qrbsp_addr_t;
    typedef logic [QRB_WORD_W-1:0] qrbsp_word_t;
    typedef enum logic [1:0] {QRB_LAST_IDLE = 2'h0, QRB_LAST_READ = 2'h1,
                              QRB_LAST_WRITE = 2'h3} qrbsp_last_e;
endpackage
`default_nettype wire

//--- common/qrbsp_wr_if.sv
// Purpose: write commit path between the port control and the array
// Assumes: one clock
// Notes: a whole burst with its lane enables per commit, so alternate-cycle writes keep up
`default_nettype none
interface qrbsp_wr_if;
    import qrbsp_pkg::*;
    logic we;
    qrbsp_addr_t addr;
    logic [QRB_BURST*QRB_WORD_W-1:0] data;
    logic [QRB_BURST*QRB_LANES-1:0] lane_en;
    modport src (output we, output addr, output data, output lane_en);
    modport dst (input we, input addr, input data, input lane_en);
endinterface
`default_nettype wire

//--- rtl/qrbsp_array.sv
// Purpose: storage array with per-lane write
// Assumes: read is combinational on the address
// Notes: write lands at the clock edge
`default_nettype none
module qrbsp_array
    import qrbsp_pkg::*;
(
    input wire logic clk,
    input wire logic ce,
    qrbsp_wr_if.dst wr,
    input wire qrbsp_addr_t rd_addr,
    output qrbsp_word_t rd_data
);
    qrbsp_word_t mem [0:(1<<QRB_ADDR_W)-1];
    assign rd_data = mem[rd_addr];
    // ----------------------------------------
    // per-lane write of all four burst words at once
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (ce && wr.we) begin
            for (int g = 0; g < QRB_BURST*QRB_LANES; g++) begin
                if (wr.lane_en[g]) begin
                    mem[wr.addr + QRB_ADDR_W'(g / QRB_LANES)][(g % QRB_LANES)*QRB_LANE_W +: QRB_LANE_W]
                        <= wr.data[g*QRB_LANE_W +: QRB_LANE_W];
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- rtl/qrbsp_zq.sv
// Purpose: periodic impedance recalibration and pll lock timing
// Assumes: clock enable freezes both counters
// Notes: lock wait is shortenable through LOCK_CYCLES
`default_nettype none
module qrbsp_zq
    import qrbsp_pkg::*;
#(
    parameter int unsigned LOCK_CYCLES = QRB_LOCK_CYCLES
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic pll_on,
    output logic cal_pulse,
    output logic locked
);
    typedef struct packed {
        logic [9:0] zq_cnt;
        logic [15:0] lock_cnt;
        logic cal;
        logic lock;
    } qrbsp_zq_s;
    qrbsp_zq_s r, next_r;
    always_comb begin
        next_r = r;
        next_r.cal = 1'b0;
        next_r.zq_cnt = r.zq_cnt + 10'h1;
        if (r.zq_cnt == 10'(QRB_ZQ_CYCLES - 1)) begin
            next_r.cal = 1'b1;
        end
        if (!pll_on) begin
            next_r.lock_cnt = 16'h0;
            next_r.lock = 1'b0;
        end else if (r.lock_cnt == 16'(LOCK_CYCLES - 1)) begin
            next_r.lock = 1'b1;
        end else begin
            next_r.lock_cnt = r.lock_cnt + 16'h1;
        end
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            r <= '0;
        end else if (ce) begin
            r <= next_r;
        end
    end
    assign cal_pulse = r.cal;
    assign locked = r.lock;
    zq_period_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce && r.cal |-> $past(r.zq_cnt) == 10'(QRB_ZQ_CYCLES - 1))
        else $error("calibration off period");
    lock_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        ce && !pll_on |=> !r.lock || !ce)
        else $error("lock without pll");
endmodule
`default_nettype wire

//--- test/qrbsp_ctrl_model.sv
// Purpose: memory controller model driving selects, address and write beats
// Assumes: pins change 1 ns after the clock rise
// Notes: released data lines show the inverse of their last value
`default_nettype none
module qrbsp_ctrl_model
    import qrbsp_pkg::*;
(
    input wire logic clk,
    output logic rsel_n,
    output logic wsel_n,
    output logic [QRB_ADDR_W-1:0] addr,
    output logic [QRB_WORD_W-1:0] d_pos,
    output logic [QRB_WORD_W-1:0] d_neg,
    output logic [QRB_LANES-1:0] bl_pos,
    output logic [QRB_LANES-1:0] bl_neg
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // transfers
    // ----------------------------------------
    initial begin
        {rsel_n, wsel_n} = 2'h3;
        addr = '0;
        {d_pos, d_neg} = '0;
        {bl_pos, bl_neg} = 4'hf;
    end
    // one start per call, so never a read and a write together
    task automatic write_burst(input logic [QRB_ADDR_W-1:0] a, input logic [4*QRB_WORD_W-1:0] w,
                               input logic [QRB_LANES-1:0] lp, input logic [QRB_LANES-1:0] ln);
        @(posedge clk) #1 wsel_n = 1'b0;
        @(posedge clk) #1 wsel_n = 1'b1;
        addr = a;
        @(posedge clk) #1 addr = ~a;
        @(posedge clk) #1 {d_pos, d_neg} = w[71:36];
        {bl_pos, bl_neg} = {lp, ln};
        @(posedge clk) #1 {d_pos, d_neg} = w[35:0];
        @(posedge clk) #1 {d_pos, d_neg} = ~w[35:0];
        {bl_pos, bl_neg} = 4'hf;
    endtask
    // holding select for two rises makes a back-to-back request; address follows the select
    task automatic read_start(input logic [QRB_ADDR_W-1:0] a, input int hold);
        @(posedge clk) #1 rsel_n = 1'b0;
        @(posedge clk) #1 addr = a;
        if (hold < 2) begin
            rsel_n = 1'b1;
        end
        @(posedge clk) #1 rsel_n = 1'b1;
        addr = ~a;
    endtask
endmodule
`default_nettype wire

//--- test/tb_quad_rate_burst4_sram_port.sv
// Purpose: self-checking bench for the burst-of-four sram port
// Assumes: pll on, output clocks not strapped, lock wait shortened to 20
// Notes: read data is awaited on the output enable, then taken word by word
`default_nettype none
module tb_quad_rate_burst4_sram_port;
    timeunit 1ns;
    timeprecision 100ps;
    import qrbsp_pkg::*;
    localparam int unsigned LOCK = 20;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic rsel_n, wsel_n;
    logic [QRB_ADDR_W-1:0] addr;
    logic [QRB_WORD_W-1:0] d_pos, d_neg, dout;
    logic [QRB_LANES-1:0] bl_pos, bl_neg;
    logic oe, echo, echo_n, single, locked, cal;
    int fail_count = 0;
    int checks = 0;
    always #5 clk = ~clk;
    // ----------------------------------------
    // partner and design
    // ----------------------------------------
    qrbsp_ctrl_model i_ctrl (.clk(clk), .rsel_n(rsel_n), .wsel_n(wsel_n), .addr(addr),
        .d_pos(d_pos), .d_neg(d_neg), .bl_pos(bl_pos), .bl_neg(bl_neg));
    qrbsp_port #(.LOCK_CYCLES(LOCK)) i_dut (.CLK(clk), .RESET_N(reset_n), .CE(1'b1),
        .READ_PORT_SELECT_N(rsel_n), .WRITE_PORT_SELECT_N(wsel_n), .ADDR(addr),
        .DATA_IN_POS(d_pos), .DATA_IN_NEG(d_neg), .BYTE_LANE_WRITE_N_POS(bl_pos),
        .BYTE_LANE_WRITE_N_NEG(bl_neg), .PLL_OFF_N(1'b1), .OUT_CLK_STRAP(1'b0),
        .DATA_OUT(dout), .DATA_OUT_OE(oe), .ECHO_CLOCK(echo), .ECHO_CLOCK_N(echo_n),
        .SINGLE_CLOCK(single), .PLL_LOCKED(locked), .IMPEDANCE_CAL(cal));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        if (fail_count == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // waits for the burst, takes four words, then expects the outputs released
    task automatic expect_burst(input logic [4*QRB_WORD_W-1:0] w);
        int n;
        n = 0;
        while (oe !== 1'b1 && n < 12) begin
            @(posedge clk) #1 n++;
        end
        check("read start", oe, 1'b1);
        for (int i = 0; i < 4; i++) begin
            check("read word", dout, w[71-18*i -: 18]);
            check("read enable", oe, 1'b1);
            @(posedge clk) #1;
        end
        check("tristate after burst", oe, 1'b0);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        check("enable at reset", oe, 1'b0);
        check("lock at reset", locked, 1'b0);
        reset_n = 1'b1;
        repeat (LOCK + 8) @(posedge clk);
        #1 check("pll locked", locked, 1'b1);
        check("single clock", single, 1'b0);
        check("echo pair", echo_n ^ echo, 1'b1);
    endtask
    task automatic t_write_read();
        i_ctrl.write_burst(8'h10, {18'h00001, 18'h3ff02, 18'h15503, 18'h2aa04}, 2'h0, 2'h0);
        i_ctrl.read_start(8'h10, 1);
        expect_burst({18'h00001, 18'h3ff02, 18'h15503, 18'h2aa04});
    endtask
    task automatic t_lanes();
        i_ctrl.write_burst(8'h20, {4{18'h12345}}, 2'h0, 2'h0);
        // lower lane masked on positive beats, both lanes masked on negative beats
        i_ctrl.write_burst(8'h20, {4{18'h3fe00}}, 2'h1, 2'h3);
        i_ctrl.read_start(8'h20, 1);
        expect_burst({18'h3ff45, 18'h12345, 18'h3ff45, 18'h12345});
    endtask
    task automatic t_back_to_back();
        i_ctrl.write_burst(8'h30, {18'h0000a, 18'h0000b, 18'h0000c, 18'h0000d}, 2'h0, 2'h0);
        // second rise of the select is a request that must be dropped
        i_ctrl.read_start(8'h30, 2);
        expect_burst({18'h0000a, 18'h0000b, 18'h0000c, 18'h0000d});
        repeat (4) @(posedge clk);
        #1 check("no second burst", oe, 1'b0);
    endtask
    task automatic t_calibration();
        int n;
        n = 0;
        while (cal !== 1'b1 && n < 1100) begin
            @(posedge clk) #1 n++;
        end
        n = 0;
        @(posedge clk) #1;
        while (cal !== 1'b1 && n < 1100) begin
            @(posedge clk) #1 n++;
        end
        check("calibration period", n + 1, QRB_ZQ_CYCLES);
    endtask
    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge clk);
        #1 t_reset();
        t_write_read();
        t_lanes();
        t_back_to_back();
        t_calibration();
        report_and_stop();
    end
    initial begin
        #50us;
        fail_count++;
        report_and_stop();
    end
endmodule
`default_nettype wire
